// file: pkg/pfc_pkg.sv
`default_nettype none
package pfc_pkg;
    localparam int         ADDR_W        = 18;
    localparam int         DATA_W        = 16;
    localparam logic [17:0] UNLOCK_ADDR1 = 18'h05555;
    localparam logic [17:0] UNLOCK_ADDR2 = 18'h02AAA;
    localparam logic [7:0] CMD_UNLOCK1   = 8'hAA;
    localparam logic [7:0] CMD_UNLOCK2   = 8'h55;
    localparam logic [7:0] CMD_PROGRAM   = 8'hA0;
    localparam logic [7:0] CMD_ERASE     = 8'h80;
    localparam logic [7:0] CMD_ID_ENTRY  = 8'h90;
    localparam logic [7:0] CMD_QUERY     = 8'h98;
    localparam logic [7:0] CMD_EXIT      = 8'hF0;
    localparam logic [7:0] CMD_SECTOR    = 8'h30;
    localparam logic [7:0] CMD_BLOCK     = 8'h50;
    localparam logic [7:0] CMD_CHIP      = 8'h10;
    localparam logic [7:0] UPPER_FILL    = 8'h00;
    localparam int         SECTOR_LSB    = 11;
    localparam int         BLOCK_LSB     = 15;
    localparam int         TOGGLE_BIT    = 6;
    localparam int         POLL_BIT      = 7;
    // Bus phase timing at 10 MHz
    localparam int         CLK_NS        = 100;
    localparam int         STROBE_NS     = 200;
    localparam int         STROBE_CYC    = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int         READ_NS       = 200;
    localparam int         READ_CYC      = (READ_NS + CLK_NS - 1) / CLK_NS;
    localparam int         GAP_NS        = 100;
    localparam int         GAP_CYC       = (GAP_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] CNT_RESET     = 4'h0;
    localparam logic [2:0] STEP_RESET    = 3'h0;

    typedef enum logic [2:0] {
        PFC_OP_READ, PFC_OP_PROGRAM, PFC_OP_SECTOR, PFC_OP_BLOCK,
        PFC_OP_CHIP, PFC_OP_ID, PFC_OP_QUERY, PFC_OP_EXIT
    } pfc_op_t;

    typedef struct packed {
        pfc_op_t            op;
        logic [17:0]        addr;
        logic [15:0]        data;
    } pfc_req_t;

    typedef struct packed {
        logic        ce_n;
        logic        oe_n;
        logic        we_n;
        logic [17:0] addr;
        logic [15:0] dq;
        logic        dq_oe;
    } pfc_pins_t;
endpackage : pfc_pkg
`default_nettype wire

// file: design/pfc_host.sv
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Operation
// - Program preceded by three unlock cycles; erase is six cycles.
// - Upper eight data lines driven to valid levels during commands.
// - Query entry: three cycles, last writes 98H at 5555H.
// - Query mode holds until the exit command is written.
// - Sector erase ends 30H at sector; block erase 50H at block.
// - Chip erase ends 10H at 5555H in the sixth cycle.
module pfc_host
    import pfc_pkg::*;
(
    // Clock and reset
    input  wire logic              core_clk_i,
    input  wire logic              rst_i,
    // User request
    input  wire logic              req_valid_i,
    input  wire pfc_req_t          req_i,
    output logic                   req_ready_o,
    output logic                   rsp_valid_o,
    output logic [DATA_W-1:0]      rsp_data_o,
    // Flash pins
    output logic                   ce_n_o,
    output logic                   oe_n_o,
    output logic                   we_n_o,
    output logic [ADDR_W-1:0]      addr_o,
    output logic [DATA_W-1:0]      dq_o,
    output logic                   dq_oe_o,
    input  wire logic [DATA_W-1:0] dq_i
);
    typedef enum logic [2:0] {
        PFC_IDLE, PFC_SETUP, PFC_STROBE, PFC_GAP, PFC_READ, PFC_POLL
    } pfc_state_t;

    pfc_state_t        state_q;
    pfc_req_t          cur_q;
    pfc_pins_t         pins_q;
    logic [2:0]        step_q;
    logic [3:0]        cnt_q;
    logic              poll_first_q;
    logic              last_tog_q;
    logic [DATA_W-1:0] rsp_q;
    logic              rsp_v_q;
    logic [DATA_W-1:0] s1_q, s2_q, s3_q;
    logic [DATA_W-1:0] dq_sync;

    ////////////////////////////////////////////////////////////////////////
    // Cycle table
    logic [2:0]        n_steps;
    logic [17:0]       cyc_addr;
    logic [7:0]        cyc_data;
    logic              is_alter;
    logic [17:0]       sect_addr;
    logic [17:0]       blk_addr;
    assign sect_addr = {cur_q.addr[17:SECTOR_LSB], 11'h000};
    assign blk_addr  = {cur_q.addr[17:BLOCK_LSB], 15'h0000};
    assign is_alter  = (cur_q.op inside {PFC_OP_PROGRAM, PFC_OP_SECTOR, PFC_OP_BLOCK, PFC_OP_CHIP});

    always_comb
    begin
        n_steps = 3'h3;
        case (cur_q.op)
            PFC_OP_READ:    n_steps = 3'h0;
            PFC_OP_PROGRAM: n_steps = 3'h4;
            PFC_OP_SECTOR,
            PFC_OP_BLOCK,
            PFC_OP_CHIP:    n_steps = 3'h6;
            PFC_OP_EXIT:    n_steps = 3'h1;
            default:        n_steps = 3'h3;
        endcase
    end

    // Unlock pairs at steps 0,1 and 3,4; command at 2 and 5
    always_comb
    begin
        cyc_addr = UNLOCK_ADDR1;
        cyc_data = CMD_UNLOCK1;
        case (step_q)
            3'h0, 3'h3:
            begin
                cyc_addr = UNLOCK_ADDR1;
                cyc_data = CMD_UNLOCK1;
            end
            3'h1, 3'h4:
            begin
                cyc_addr = UNLOCK_ADDR2;
                cyc_data = CMD_UNLOCK2;
            end
            3'h2:
            begin
                cyc_addr = UNLOCK_ADDR1;
                case (cur_q.op)
                    PFC_OP_PROGRAM: cyc_data = CMD_PROGRAM;
                    PFC_OP_ID:      cyc_data = CMD_ID_ENTRY;
                    PFC_OP_QUERY:   cyc_data = CMD_QUERY;
                    PFC_OP_EXIT:    cyc_data = CMD_EXIT;
                    default:        cyc_data = CMD_ERASE;
                endcase
            end
            3'h5:
            begin
                case (cur_q.op)
                    PFC_OP_SECTOR:
                    begin
                        cyc_addr = sect_addr;
                        cyc_data = CMD_SECTOR;
                    end
                    PFC_OP_BLOCK:
                    begin
                        cyc_addr = blk_addr;
                        cyc_data = CMD_BLOCK;
                    end
                    default:
                    begin
                        cyc_addr = UNLOCK_ADDR1;
                        cyc_data = CMD_CHIP;
                    end
                endcase
            end
            default:
            begin
                cyc_addr = UNLOCK_ADDR1;
                cyc_data = CMD_UNLOCK1;
            end
        endcase
    end

    // Single-cycle exit writes F0H, program data word goes at step 3
    logic              data_step;
    logic [15:0]       wr_word;
    logic [17:0]       wr_addr;
    logic              last_step;
    assign data_step = (cur_q.op == PFC_OP_PROGRAM) && (step_q == 3'h3);
    assign wr_word   = data_step ? cur_q.data :
                       (cur_q.op == PFC_OP_EXIT) ? {UPPER_FILL, CMD_EXIT} :
                       {UPPER_FILL, cyc_data};
    assign wr_addr   = data_step ? cur_q.addr :
                       (cur_q.op == PFC_OP_EXIT) ? cur_q.addr : cyc_addr;
    assign last_step = (step_q == n_steps - 3'h1);

    ////////////////////////////////////////////////////////////////////////
    // Read data synchroniser, second and third must agree
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s1_q <= 16'h0000;
            s2_q <= 16'h0000;
            s3_q <= 16'h0000;
        end
        else
        begin
            s1_q <= dq_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    assign dq_sync = s3_q;
    logic stable;
    assign stable = (s2_q == s3_q);

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_q      <= PFC_IDLE;
            cur_q        <= '0;
            pins_q       <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, dq: '0, dq_oe: 1'b0};
            step_q       <= STEP_RESET;
            cnt_q        <= CNT_RESET;
            poll_first_q <= 1'b0;
            last_tog_q   <= 1'b0;
            rsp_q        <= 16'h0000;
            rsp_v_q      <= 1'b0;
        end
        else
        begin
            rsp_v_q <= 1'b0;
            case (state_q)
                PFC_IDLE:
                    if (req_valid_i)
                    begin
                        cur_q   <= req_i;
                        step_q  <= STEP_RESET;
                        cnt_q   <= CNT_RESET;
                        state_q <= PFC_SETUP;
                    end
                PFC_SETUP:
                begin
                    pins_q.ce_n <= 1'b0;
                    pins_q.oe_n <= (n_steps == 3'h0) ? 1'b0 : 1'b1;
                    pins_q.addr <= (n_steps == 3'h0) ? cur_q.addr : wr_addr;
                    pins_q.dq   <= wr_word;
                    pins_q.dq_oe <= (n_steps != 3'h0);
                    cnt_q       <= CNT_RESET;
                    state_q     <= (n_steps == 3'h0) ? PFC_READ : PFC_STROBE;
                end
                PFC_STROBE:
                begin
                    pins_q.we_n <= 1'b0;
                    cnt_q       <= cnt_q + 4'h1;
                    if (cnt_q == 4'(STROBE_CYC))
                    begin
                        pins_q.we_n <= 1'b1;
                        cnt_q       <= CNT_RESET;
                        state_q     <= PFC_GAP;
                    end
                end
                PFC_GAP:
                begin
                    pins_q.ce_n  <= 1'b1;
                    pins_q.dq_oe <= 1'b0;
                    cnt_q        <= cnt_q + 4'h1;
                    if (cnt_q == 4'(GAP_CYC))
                    begin
                        cnt_q  <= CNT_RESET;
                        step_q <= step_q + 3'h1;
                        if (!last_step)
                            state_q <= PFC_SETUP;
                        else if (is_alter)
                        begin
                            // Status valid only now, after last strobe
                            poll_first_q <= 1'b1;
                            pins_q.ce_n  <= 1'b0;
                            pins_q.oe_n  <= 1'b0;
                            state_q      <= PFC_POLL;
                        end
                        else
                        begin
                            rsp_v_q <= 1'b1;
                            state_q <= PFC_IDLE;
                        end
                    end
                end
                PFC_READ, PFC_POLL:
                begin
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q >= 4'(READ_CYC + 2) && stable)
                    begin
                        // Deselect between polls so each is a fresh read
                        pins_q.ce_n <= 1'b1;
                        pins_q.oe_n <= 1'b1;
                        cnt_q       <= CNT_RESET;
                        rsp_q       <= dq_sync;
                        last_tog_q  <= dq_sync[TOGGLE_BIT];
                        poll_first_q <= 1'b0;
                        if (state_q == PFC_READ)
                        begin
                            rsp_v_q <= 1'b1;
                            state_q <= PFC_IDLE;
                        end
                        else if (!poll_first_q && dq_sync[TOGGLE_BIT] == last_tog_q)
                        begin
                            rsp_v_q <= 1'b1;
                            state_q <= PFC_IDLE;
                        end
                        else
                            state_q <= PFC_POLL;
                    end
                end
                default:
                    state_q <= PFC_IDLE;
            endcase
            // Reselect after one idle cycle; a write here would corrupt the part
            if (state_q == PFC_POLL && cnt_q == CNT_RESET)
            begin
                pins_q.ce_n <= 1'b0;
                pins_q.oe_n <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign req_ready_o = (state_q == PFC_IDLE);
    assign rsp_valid_o = rsp_v_q;
    assign rsp_data_o  = rsp_q;
    assign ce_n_o      = pins_q.ce_n;
    assign oe_n_o      = pins_q.oe_n;
    assign we_n_o      = pins_q.we_n;
    assign addr_o      = pins_q.addr;
    assign dq_o        = pins_q.dq;
    assign dq_oe_o     = pins_q.dq_oe;

    ////////////////////////////////////////////////////////////////////////
    AST_WE_ONLY_SELECTED: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !we_n_o |-> (!ce_n_o && oe_n_o))
        else $error("write strobe without select or with output enable");
    AST_NO_DRIVE_ON_READ: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !oe_n_o |-> !dq_oe_o)
        else $error("bus contention on read");
    AST_STROBE_WIDTH: assert property (@(posedge core_clk_i) disable iff (rst_i)
        $fell(we_n_o) |-> !we_n_o [*2])
        else $error("write strobe too short");
    AST_UPPER_VALID: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (!we_n_o && cur_q.op != PFC_OP_PROGRAM) |-> dq_o[15:8] == UPPER_FILL)
        else $error("upper lines not driven low in command");
    AST_BUSY_NO_ACCEPT: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (state_q == PFC_POLL) |-> !req_ready_o)
        else $error("request accepted while device busy");
    sequence s_strobe_rise;
        $rose(we_n_o);
    endsequence
    sequence s_data_held;
        $stable(dq_o) && dq_oe_o && !ce_n_o;
    endsequence
    AST_DATA_HELD_AT_RISE: assert property (@(posedge core_clk_i) disable iff (rst_i)
        s_strobe_rise |-> s_data_held ##1 ce_n_o)
        else $error("write data or select dropped at strobe end");
    AST_STANDBY_RELEASE: assert property (@(posedge core_clk_i) disable iff (rst_i)
        ce_n_o |-> !dq_oe_o)
        else $error("host drives data while deselected");
endmodule // pfc_host
`default_nettype wire

// file: verification/pfc_flash_model.sv
`default_nettype none
module pfc_flash_model
    import pfc_pkg::*;
#(
    parameter int          PROG_READS  = 3,
    parameter int          ERASE_READS = 5,
    parameter logic [15:0] MAKER_CODE  = 16'h00A5,  // Arbitrary value
    parameter logic [15:0] PART_CODE   = 16'h0C3D   // Arbitrary value
)
(
    // Flash pins
    input  wire logic              ce_n_i,
    input  wire logic              oe_n_i,
    input  wire logic              we_n_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] dq_i,
    output logic [DATA_W-1:0]      dq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [0:(1<<ADDR_W)-1];
    int          step_q   = 0;
    int          busy_q   = 0;
    int          wr_cnt   = 0;
    int          poll_cnt = 0;
    logic        tog_q    = 1'b0;
    logic        prog_q   = 1'b0;
    logic [15:0] pdat_q   = 16'h0000;
    logic [1:0]  mode_q   = 2'h0;
    logic [15:0] rd_q     = 16'h0000;
    logic [15:0] flt_q    = 16'h0000;
    realtime     t_fall   = 0.0;
    wire logic   rd_n     = ce_n_i | oe_n_i;
    wire logic   hit1     = addr_i[14:0] == 15'h5555;
    initial
        foreach (mem[k])
            mem[k] = 16'hFFFF;
    //////////////////////////////////////////////////////////////////////////
    task automatic erase(input int lsb);
        int base;
        base = int'(addr_i) & ~((1 << lsb) - 1);
        for (int k = base; k < base + (1 << lsb); k++)
            mem[k] = 16'hFFFF;
        prog_q = 1'b0;
        busy_q = ERASE_READS;
    endtask
    always @(negedge we_n_i)
        t_fall = $realtime;
    // Busy part drops every write, exit included
    always @(posedge we_n_i)
    begin
        if (!ce_n_i && oe_n_i && $realtime - t_fall >= 5.0 && busy_q == 0)
        begin
            wr_cnt++;
            case (step_q)
                0, 4:
                begin
                    if (dq_i[7:0] == CMD_EXIT)
                        mode_q = 2'h0;
                    step_q = (hit1 && dq_i[7:0] == CMD_UNLOCK1) ? step_q + 1 : 0;
                end
                1, 5:
                    step_q = (addr_i[14:0] == 15'h2AAA && dq_i[7:0] == CMD_UNLOCK2) ? step_q + 1 : 0;
                2:
                begin
                    step_q = 0;
                    if (hit1)
                        case (dq_i[7:0])
                            CMD_PROGRAM:  step_q = 3;
                            CMD_ERASE:    step_q = 4;
                            CMD_ID_ENTRY: mode_q = 2'h1;
                            CMD_QUERY:    mode_q = 2'h2;
                            CMD_EXIT:     mode_q = 2'h0;
                            default:      ;
                        endcase
                end
                3:
                begin
                    mem[addr_i] = mem[addr_i] & dq_i;
                    pdat_q = dq_i;
                    prog_q = 1'b1;
                    busy_q = PROG_READS;
                    step_q = 0;
                end
                default:
                begin
                    step_q = 0;
                    case (dq_i[7:0])
                        CMD_SECTOR: erase(SECTOR_LSB);
                        CMD_BLOCK:  erase(BLOCK_LSB);
                        CMD_CHIP:   if (hit1) erase(ADDR_W);
                        default:    ;
                    endcase
                end
            endcase
        end
    end
    //////////////////////////////////////////////////////////////////////////
    always @(negedge rd_n)
    begin
        if (busy_q > 0)
        begin
            tog_q = ~tog_q;
            poll_cnt++;
            busy_q--;
            rd_q = {8'h00, prog_q & ~pdat_q[7], tog_q, 6'h00};
        end
        else if (mode_q == 2'h1)
            rd_q = addr_i[0] ? PART_CODE : MAKER_CODE;
        else if (mode_q == 2'h2)
            rd_q = (addr_i == 18'h00010) ? 16'h0051 : (addr_i == 18'h00011) ? 16'h0052 :
                   (addr_i == 18'h00012) ? 16'h0059 : 16'h0000;
        else
            rd_q = mem[addr_i];
    end
    // No pull-ups: a released bus shows the inverse, never a stale match
    always @(posedge rd_n)
        flt_q = ~rd_q;
    assign dq_o = rd_n ? flt_q : rd_q;
endmodule // pfc_flash_model
`default_nettype wire

// file: verification/pfc_host_tb.sv
`default_nettype none
module pfc_host_tb
    import pfc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] MAKER = 16'h00A5;  // Arbitrary value
    localparam logic [15:0] PART  = 16'h0C3D;  // Arbitrary value
    logic              core_clk_i  = 1'b0;
    logic              rst_i       = 1'b1;
    logic              req_valid_i = 1'b0;
    pfc_req_t          req_i       = '0;
    logic              req_ready_o;
    logic              rsp_valid_o;
    logic [DATA_W-1:0] rsp_data_o;
    logic              ce_n_o;
    logic              oe_n_o;
    logic              we_n_o;
    logic [ADDR_W-1:0] addr_o;
    logic [DATA_W-1:0] dq_o;
    logic              dq_oe_o;
    logic [DATA_W-1:0] dq_w;
    wire logic [DATA_W-1:0] dq_i = dq_oe_o ? dq_o : dq_w;
    int                num_errors  = 0;
    int                comparisons = 0;
    int                cycles      = 0;
    always #50 core_clk_i = ~core_clk_i;
    pfc_host i_dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i), .req_i(req_i),
        .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .ce_n_o(ce_n_o),
        .oe_n_o(oe_n_o), .we_n_o(we_n_o), .addr_o(addr_o), .dq_o(dq_o), .dq_oe_o(dq_oe_o), .dq_i(dq_i));
    pfc_flash_model #(.PROG_READS(3), .ERASE_READS(5), .MAKER_CODE(MAKER), .PART_CODE(PART)) i_flash (
        .ce_n_i(ce_n_o), .oe_n_i(oe_n_o), .we_n_i(we_n_o), .addr_i(addr_o), .dq_i(dq_i), .dq_o(dq_w));
    //////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        if (num_errors == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Whole run is several hundred cycles; the ceiling leaves wide margin
    // Pin checks at the falling edge, clear of the launching edge
    always @(negedge core_clk_i)
    begin
        cycles++;
        if (!rst_i && we_n_o === 1'b0)
            check("strobe select", 32'h1, {ce_n_o, oe_n_o});
        if (!rst_i && we_n_o === 1'b0 && i_flash.step_q != 3)
            check("upper lines", UPPER_FILL, dq_o[15:8]);
        if (!rst_i && oe_n_o === 1'b0)
            check("host release", 32'h0, dq_oe_o);
        if (cycles == 30000)
        begin
            num_errors++;
            test_done();
        end
    end
    task automatic do_op(input pfc_op_t op, input logic [17:0] a, input logic [15:0] d,
                         input int writes, output logic [15:0] q);
        int n;
        int w0;
        w0 = i_flash.wr_cnt;
        check("ready idle", 32'h1, req_ready_o);
        req_i = '{op, a, d};
        req_valid_i = 1'b1;
        @(negedge core_clk_i);
        req_valid_i = 1'b0;
        check("ready busy", 32'h0, req_ready_o);
        n = 0;
        while (rsp_valid_o !== 1'b1 && n < 5000)
        begin
            @(negedge core_clk_i);
            n++;
        end
        q = rsp_data_o;
        check("response", 32'h1, rsp_valid_o);
        check("write cycles", writes, i_flash.wr_cnt - w0);
        check("device idle", 32'h0, i_flash.busy_q);
        @(negedge core_clk_i);
    endtask
    task automatic read_chk(input logic [17:0] a, input logic [15:0] exp);
        logic [15:0] q;
        do_op(PFC_OP_READ, a, 16'h0000, 0, q);
        check("read data", exp, q);
    endtask
    //////////////////////////////////////////////////////////////////////////
    task automatic t_program();
        int p0;
        logic [15:0] q;
        p0 = i_flash.poll_cnt;
        do_op(PFC_OP_PROGRAM, 18'h01234, 16'h5A3C, 4, q);
        check("poll reads", 32'h3, i_flash.poll_cnt - p0);
        read_chk(18'h01234, 16'h5A3C);
    endtask
    task automatic t_sector();
        logic [15:0] q;
        do_op(PFC_OP_PROGRAM, 18'h00800, 16'h1111, 4, q);
        do_op(PFC_OP_PROGRAM, 18'h01000, 16'h2222, 4, q);
        do_op(PFC_OP_SECTOR, 18'h00FFF, 16'h0000, 6, q);
        read_chk(18'h00800, 16'hFFFF);
        read_chk(18'h01000, 16'h2222);
    endtask
    task automatic t_block_chip();
        logic [15:0] q;
        do_op(PFC_OP_PROGRAM, 18'h08000, 16'h3333, 4, q);
        do_op(PFC_OP_PROGRAM, 18'h10000, 16'h4444, 4, q);
        do_op(PFC_OP_BLOCK, 18'h0FFFF, 16'h0000, 6, q);
        read_chk(18'h08000, 16'hFFFF);
        read_chk(18'h10000, 16'h4444);
        do_op(PFC_OP_CHIP, 18'h05555, 16'h0000, 6, q);
        read_chk(18'h10000, 16'hFFFF);
    endtask
    task automatic t_ident();
        logic [15:0] q;
        do_op(PFC_OP_ID, 18'h00000, 16'h0000, 3, q);
        read_chk(18'h00000, MAKER);
        read_chk(18'h00001, PART);
        do_op(PFC_OP_EXIT, 18'h3ABCD, 16'h0000, 1, q);
        read_chk(18'h00001, 16'hFFFF);
    endtask
    task automatic t_query();
        logic [15:0] q;
        do_op(PFC_OP_QUERY, 18'h00000, 16'h0000, 3, q);
        read_chk(18'h00010, 16'h0051);
        read_chk(18'h00012, 16'h0059);
        do_op(PFC_OP_EXIT, 18'h00010, 16'h0000, 1, q);
        read_chk(18'h00010, 16'hFFFF);
    endtask
    initial
    begin
        repeat (8) @(posedge core_clk_i);
        @(negedge core_clk_i);
        rst_i = 1'b0;
        @(negedge core_clk_i);
        t_program();
        t_sector();
        t_block_chip();
        t_ident();
        t_query();
        test_done();
    end
endmodule // pfc_host_tb
`default_nettype wire
